// ===== core/disk_iface_pkg.sv
package disk_iface_pkg;
  // ************************************************************
  // geometry and timing
  // ************************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned SETTLE_US = 10;
  localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int unsigned REV_US = 16667;
  localparam int unsigned REV_CYC = REV_US * CLK_MHZ;
  localparam int unsigned INDEX_US = 2;
  localparam int unsigned INDEX_CYC = INDEX_US * CLK_MHZ;
  localparam int unsigned TRACKS = 615;
  localparam int unsigned TRK_W = 10;
  localparam int unsigned SEL_LINES = 4;
  localparam logic [TRK_W-1:0] TRACK_ZERO = 10'h000;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic writeGate;
    logic reducedCurrent;
    logic flux;
  } wr_cmd_t;

  typedef struct packed {
    logic seekDone;
    logic atTrackZero;
    logic fault;
    logic index;
    logic selected;
  } drv_stat_t;

  typedef enum logic [1:0] {
    HEAD_IDLE = 2'b00,
    HEAD_SETTLE = 2'b01,
    HEAD_FAULT = 2'b10
  } head_state_t;
endpackage

// ===== core/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= INIT;
      dout <= INIT;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule // pin_sync
`default_nettype wire

// ===== core/winchester_drive_control_interface.sv
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - reduced current applies only while writing
// - write path when gate low, else read
// - direction low steps inward, else outward
// - one track per step rising edge
// - respond only to strapped select line
// - seek complete after heads settle
// - track zero flag at outermost track
// - fault drives output low, blocks write/step
// - index pulse once per revolution
// - selected status low while selected
// - read flux as differential pulse pair
// - write flux on true-over-complement edge
module winchester_drive_control_interface #(
  parameter int unsigned SETTLE_CYCLES = disk_iface_pkg::SETTLE_CYC,
  parameter int unsigned REV_CYCLES = disk_iface_pkg::REV_CYC,
  parameter int unsigned INDEX_CYCLES = disk_iface_pkg::INDEX_CYC,
  parameter int unsigned NUM_TRACKS = disk_iface_pkg::TRACKS
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [1:0] strapSel,
  input wire logic unit_pick_1_n,
  input wire logic unit_pick_2_n,
  input wire logic unit_pick_3_n,
  input wire logic unit_pick_4_n,
  input wire logic writeGate_n,
  input wire logic reducedCurrent_n,
  input wire logic dirIn_n,
  input wire logic step_n,
  input wire logic wr_flux_p,
  input wire logic wr_flux_n,
  input wire logic faultDetect,
  input wire logic faultClear,
  input wire logic headFlux,
  output logic seekDone_n,
  output logic outer_track_n,
  output logic writeFault_n,
  output logic index_n,
  output logic selected_n,
  output logic rd_flux_p,
  output logic rd_flux_n,
  output logic writeEnable,
  output logic readEnable,
  output logic reducedWrite,
  output logic fluxReverse,
  output logic [disk_iface_pkg::TRK_W-1:0] track
);
  import disk_iface_pkg::*;

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int unsigned NSYNC = 13;
  logic [NSYNC-1:0] rawIn;
  logic [NSYNC-1:0] syncIn;
  assign rawIn = {unit_pick_1_n, unit_pick_2_n, unit_pick_3_n,
                  unit_pick_4_n, writeGate_n, reducedCurrent_n, dirIn_n,
                  step_n, wr_flux_p, wr_flux_n, faultDetect, faultClear,
                  headFlux};

  // idle levels: active-low pins and wr_flux_n high, wr_flux_p, faults and head flux low
  pin_sync #(.WIDTH(NSYNC), .INIT(13'h1fe8)) u_sync (
    .mclk(mclk),
    .nrst(nrst),
    .din(rawIn),
    .dout(syncIn)
  );

  logic [SEL_LINES-1:0] pickN;
  logic wgN;
  logic rcN;
  logic dirN;
  logic stepN;
  logic wfP;
  logic wfN;
  logic fltDet;
  logic fltClr;
  logic hdFlux;
  assign pickN = syncIn[12:9];
  assign wgN = syncIn[8];
  assign rcN = syncIn[7];
  assign dirN = syncIn[6];
  assign stepN = syncIn[5];
  assign wfP = syncIn[4];
  assign wfN = syncIn[3];
  assign fltDet = syncIn[2];
  assign fltClr = syncIn[1];
  assign hdFlux = syncIn[0];

  // ************************************************************
  // selection
  // ************************************************************
  // the strap is a pin too, so it passes two flops before use
  logic [1:0] strapSync;
  pin_sync #(.WIDTH(2), .INIT(2'h0)) u_strap (
    .mclk(mclk),
    .nrst(nrst),
    .din(strapSel),
    .dout(strapSync)
  );

  // strap frozen once the synchroniser has filled after reset
  logic [1:0] warm_r;
  logic [1:0] strap_r;
  logic strapTaken_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      warm_r <= 2'h0;
      strap_r <= 2'h0;
      strapTaken_r <= 1'b0;
    end else begin
      warm_r <= {warm_r[0], 1'b1};
      if (warm_r[1] && !strapTaken_r) begin
        strap_r <= strapSync;
        strapTaken_r <= 1'b1;
      end
    end
  end

  // pickN[3] is line 1 ... pickN[0] is line 4
  logic [SEL_LINES-1:0] lineHit;
  for (genvar i = 0; i < SEL_LINES; i++) begin : g_line
    assign lineHit[i] = ~pickN[SEL_LINES-1-i] & (strap_r == 2'(i));
  end
  logic selected;
  assign selected = strapTaken_r & (|lineHit);

  // ************************************************************
  // step edge and fault
  // ************************************************************
  logic stepPrev_r;
  logic wfDiffPrev_r;
  logic hdPrev_r;
  logic faultLatched_r;
  head_state_t state_r, state_nxt;
  logic stepRise;
  logic stepTake;
  assign stepRise = stepN & ~stepPrev_r;
  // inputs other than the fault lines ignored unless selected; stepping blocked under fault
  assign stepTake = stepRise & selected & ~faultLatched_r
                    & (state_r != HEAD_FAULT);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stepPrev_r <= 1'b1;
      faultLatched_r <= 1'b0;
    end else begin
      stepPrev_r <= stepN;
      // detection wins over a clear in the same cycle
      faultLatched_r <= fltDet | (faultLatched_r & ~fltClr);
    end
  end

  // ************************************************************
  // head position and settle
  // ************************************************************
  localparam int unsigned SC_W = $clog2(SETTLE_CYCLES + 1);
  localparam logic [TRK_W-1:0] TRACK_MAX = TRK_W'(NUM_TRACKS - 1);
  logic [SC_W-1:0] settle_r, settle_nxt;
  logic [TRK_W-1:0] track_r, track_nxt;
  logic inward;
  assign inward = ~dirN;

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    track_nxt = track_r;
    case (state_r)
      HEAD_IDLE, HEAD_SETTLE: begin
        if (faultLatched_r) begin
          state_nxt = HEAD_FAULT;
        end else if (stepTake) begin
          // one track per edge, clamped at the ends of the stroke
          if (inward && track_r != TRACK_MAX) begin
            track_nxt = track_r + 1'b1;
          end else if (!inward && track_r != TRACK_ZERO) begin
            track_nxt = track_r - 1'b1;
          end
          state_nxt = HEAD_SETTLE;
          settle_nxt = SC_W'(SETTLE_CYCLES - 1);
        end else if (state_r == HEAD_SETTLE) begin
          if (settle_r == '0) begin
            state_nxt = HEAD_IDLE;
          end else begin
            settle_nxt = settle_r - 1'b1;
          end
        end
      end
      HEAD_FAULT: begin
        if (!faultLatched_r) begin
          state_nxt = HEAD_SETTLE;
          settle_nxt = SC_W'(SETTLE_CYCLES - 1);
        end
      end
      default: state_nxt = HEAD_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_r <= HEAD_IDLE;
      settle_r <= '0;
      track_r <= TRACK_ZERO;
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      track_r <= track_nxt;
    end
  end

  // ************************************************************
  // spindle index
  // ************************************************************
  localparam int unsigned RV_W = $clog2(REV_CYCLES);
  logic [RV_W-1:0] rev_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rev_r <= '0;
    end else if (rev_r == RV_W'(REV_CYCLES - 1)) begin
      rev_r <= '0;
    end else begin
      rev_r <= rev_r + 1'b1;
    end
  end
  logic indexPulse;
  // pulse sits at the end, so its falling edge starts the track
  assign indexPulse = rev_r >= RV_W'(REV_CYCLES - INDEX_CYCLES);

  // ************************************************************
  // read / write path
  // ************************************************************
  logic writing;
  logic wfDiff;
  logic wrFlux;
  logic hdEdge;
  // write blocked under fault or when not selected
  assign writing = selected & ~wgN & ~faultLatched_r;
  // a reversal is the true line rising above the complement
  assign wfDiff = wfP & ~wfN;
  assign wrFlux = writing & wfDiff & ~wfDiffPrev_r;
  // head pulses under one clock wide may be lost in the sync
  assign hdEdge = hdFlux & ~hdPrev_r;

  logic [1:0] rdPair_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wfDiffPrev_r <= 1'b0;
      hdPrev_r <= 1'b0;
      rdPair_r <= 2'b01;
    end else begin
      wfDiffPrev_r <= wfDiff;
      hdPrev_r <= hdFlux;
      // one-cycle true-high pulse per read flux transition
      if (selected && wgN && hdEdge) begin
        rdPair_r <= 2'b10;
      end else begin
        rdPair_r <= 2'b01;
      end
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  drv_stat_t stat_r;
  wr_cmd_t wcmd_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_r <= '0;
      wcmd_r <= '0;
    end else begin
      stat_r.seekDone <= selected & (state_r == HEAD_IDLE);
      stat_r.atTrackZero <= selected & (track_r == TRACK_ZERO);
      stat_r.fault <= selected & faultLatched_r;
      stat_r.index <= selected & indexPulse;
      stat_r.selected <= selected;
      wcmd_r.writeGate <= writing;
      // reduced current only counts while the write gate is on
      wcmd_r.reducedCurrent <= writing & ~rcN;
      wcmd_r.flux <= wrFlux;
    end
  end

  assign seekDone_n = ~stat_r.seekDone;
  assign outer_track_n = ~stat_r.atTrackZero;
  assign writeFault_n = ~stat_r.fault;
  assign index_n = ~stat_r.index;
  assign selected_n = ~stat_r.selected;
  assign rd_flux_p = rdPair_r[1];
  assign rd_flux_n = rdPair_r[0];
  assign writeEnable = wcmd_r.writeGate;
  assign readEnable = ~wcmd_r.writeGate;
  assign reducedWrite = wcmd_r.reducedCurrent;
  assign fluxReverse = wcmd_r.flux;
  assign track = track_r;
endmodule // winchester_drive_control_interface
`default_nettype wire

// ===== dv/drv_sva.sv
`timescale 1ns/10ps
`default_nettype none
module drv_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic seekDone_n,
  input wire logic outer_track_n,
  input wire logic writeFault_n,
  input wire logic index_n,
  input wire logic selected_n,
  input wire logic rd_flux_p,
  input wire logic rd_flux_n,
  input wire logic writeEnable,
  input wire logic readEnable,
  input wire logic reducedWrite,
  input wire logic fluxReverse,
  input wire logic [disk_iface_pkg::TRK_W-1:0] track
);
  import disk_iface_pkg::*;
  // *****
  // port relations
  // *****
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  property p_rw; readEnable == !writeEnable
    && (!writeEnable || !selected_n && writeFault_n); endproperty
  a_rw: assert property (p_rw)
    else $error("read and write paths overlap");
  property p_red; reducedWrite |-> writeEnable; endproperty
  a_red: assert property (p_red)
    else $error("reduced current while not writing");
  property p_step; $changed(track) |-> track == $past(track) + 1'b1
    || track == $past(track) - 1'b1; endproperty
  a_step: assert property (p_step)
    else $error("track moved by more than one");
  property p_sk; $changed(track) |=> seekDone_n; endproperty
  a_sk: assert property (p_sk)
    else $error("seek done kept during a move");
  // the bench runs the design with a settle of four cycles
  property p_set; $fell(seekDone_n) |-> $past(seekDone_n, 4)
    && track == $past(track, 3); endproperty
  a_set: assert property (p_set)
    else $error("seek done before heads settled");
  property p_t0; !outer_track_n |-> track == TRACK_ZERO
    || $past(track) == TRACK_ZERO; endproperty
  a_t0: assert property (p_t0)
    else $error("track zero flag off track zero");
  property p_rd; rd_flux_p |-> !rd_flux_n && readEnable ##1 !rd_flux_p;
  endproperty
  a_rd: assert property (p_rd)
    else $error("bad read flux pulse");
  property p_fr; fluxReverse |-> writeEnable ##1 !fluxReverse; endproperty
  a_fr: assert property (p_fr)
    else $error("bad flux reversal pulse");
  property p_flt; !writeFault_n && $past(!writeFault_n) |-> !writeEnable
    && track == $past(track); endproperty
  a_flt: assert property (p_flt)
    else $error("write or step under fault");
  property p_sel; selected_n && $past(selected_n) |-> index_n
    && outer_track_n && writeFault_n && !writeEnable; endproperty
  a_sel: assert property (p_sel)
    else $error("status active while unselected");
endmodule // drv_sva
`default_nettype wire

// ===== dv/ctl_model.sv
`timescale 1ns/10ps
`default_nettype none
module ctl_model (
  input wire logic mclk,
  output logic step_n,
  output logic dirIn_n,
  output logic writeGate_n,
  output logic wr_flux_p,
  output logic wr_flux_n
);
  // *****
  // controller side of the pins
  // *****
  initial begin
    step_n = 1'b1;
    dirIn_n = 1'b1;
    writeGate_n = 1'b1;
    wr_flux_p = 1'b0; // idle pair outside writes
    wr_flux_n = 1'b1;
  end
  task automatic setGate(input logic on);
    writeGate_n = !on;
  endtask
  // gap varies so the drive sees both brisk and lazy steppers
  task automatic doStep(input logic inward, input int gap);
    @(negedge mclk);
    dirIn_n = !inward;
    step_n = 1'b0;
    repeat (gap) @(negedge mclk);
    step_n = 1'b1;
    repeat (gap) @(negedge mclk);
  endtask
  task automatic doFlux(input int n); // encoded flux only
    repeat (n) begin
      @(negedge mclk);
      wr_flux_p = 1'b1;
      wr_flux_n = 1'b0;
      repeat (2) @(negedge mclk);
      wr_flux_p = 1'b0;
      wr_flux_n = 1'b1;
      @(negedge mclk);
    end
  endtask
endmodule // ctl_model
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import disk_iface_pkg::*;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] strapSel;
  logic [3:0] pick = 4'hf;
  logic reducedCurrent_n = 1'b1;
  logic faultDetect = 1'b0;
  logic faultClear = 1'b0;
  logic headFlux = 1'b0;
  logic idxP = 1'b1;
  wire logic step_n, dirIn_n, writeGate_n, wr_flux_p, wr_flux_n;
  logic seekDone_n, outer_track_n, writeFault_n, index_n, selected_n;
  logic rd_flux_p, rd_flux_n, writeEnable, readEnable, reducedWrite;
  logic fluxReverse;
  logic [TRK_W-1:0] track;
  logic [TRK_W-1:0] prevT = '0;
  logic [TRK_W-1:0] expQ [$];
  int failures = 0, nTests = 0, expT = 0, nRev, nRd, nIdx, n;
  wire logic unit_pick_1_n = pick[0], unit_pick_2_n = pick[1];
  wire logic unit_pick_3_n = pick[2], unit_pick_4_n = pick[3];
  always #5 mclk = ~mclk;
  ctl_model ctl (.mclk, .step_n, .dirIn_n, .writeGate_n, .wr_flux_p,
    .wr_flux_n);
  winchester_drive_control_interface #(.SETTLE_CYCLES(4), .REV_CYCLES(50),
    .INDEX_CYCLES(3), .NUM_TRACKS(8)) uut (.mclk, .nrst, .strapSel,
    .unit_pick_1_n, .unit_pick_2_n, .unit_pick_3_n, .unit_pick_4_n,
    .writeGate_n, .reducedCurrent_n, .dirIn_n, .step_n, .wr_flux_p,
    .wr_flux_n, .faultDetect, .faultClear, .headFlux, .seekDone_n,
    .outer_track_n, .writeFault_n, .index_n, .selected_n, .rd_flux_p,
    .rd_flux_n, .writeEnable, .readEnable, .reducedWrite, .fluxReverse,
    .track);
  // *****
  // helpers
  // *****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nTests++;
    if (seen !== exp) begin
      failures++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d errors %0d", nTests, failures);
    if (failures == 0 && nTests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic step(input logic in, input logic ok);
    if (ok && in && expT < 7) expQ.push_back(TRK_W'(++expT));
    else if (ok && !in && expT > 0) expQ.push_back(TRK_W'(--expT));
    ctl.doStep(in, 2 + $urandom_range(3));
  endtask
  task automatic idle(input int c);
    repeat (c) @(negedge mclk);
  endtask
  always @(posedge mclk) begin
    if (nrst && track !== prevT) begin
      if (expQ.size() == 0) check(track, prevT);
      else check(track, expQ.pop_front());
    end
    prevT <= track;
    idxP <= index_n;
    if (fluxReverse === 1'b1) nRev++;
    if (rd_flux_p === 1'b1) nRd++;
    if (idxP === 1'b1 && index_n === 1'b0) nIdx++;
  end
  initial begin
    #200000;
    failures++;
    wrap_up;
  end
  // *****
  // scenarios
  // *****
  initial begin
    n = $urandom(32'h481c8fb3);
    strapSel = 2'($urandom_range(3));
    idle(2);
    nrst = 1'b1;
    idle(4);
    check(readEnable, 1);
    pick[strapSel + 2'd1] = 1'b0;
    step(1, 0);
    idle(6);
    check(selected_n, 1);
    pick = ~(4'h1 << strapSel);
    idle(8);
    check(selected_n, 0);
    check(outer_track_n, 0);
    n = 1 + $urandom_range(8);
    repeat (n) step(1, 1);
    idle(10);
    check(seekDone_n, 0);
    check(outer_track_n, 1);
    repeat (n + 1) step(0, 1);
    idle(10);
    check(outer_track_n, 0);
    nIdx = 0;
    idle(100);
    check(16'(nIdx), 2);
    reducedCurrent_n = 1'b0;
    idle(6);
    check(reducedWrite, 0);
    nRev = 0;
    ctl.setGate(1'b1);
    idle(6);
    check(writeEnable, 1);
    check(reducedWrite, 1);
    n = 1 + $urandom_range(5);
    ctl.doFlux(n);
    idle(4);
    check(16'(nRev), 16'(n));
    ctl.setGate(1'b0);
    reducedCurrent_n = 1'b1;
    nRd = 0;
    idle(6);
    repeat (n) begin
      headFlux = 1'b1;
      idle(2);
      headFlux = 1'b0;
      idle(2);
    end
    idle(4);
    check(16'(nRd), 16'(n));
    faultDetect = 1'b1;
    idle(3);
    faultDetect = 1'b0;
    idle(4);
    check(writeFault_n, 0);
    step(1, 0);
    ctl.setGate(1'b1);
    idle(6);
    check(writeEnable, 0);
    ctl.setGate(1'b0);
    faultClear = 1'b1;
    idle(3);
    faultClear = 1'b0;
    idle(12);
    check(writeFault_n, 1);
    check(seekDone_n, 0);
    pick = 4'hf;
    step(1, 0);
    idle(6);
    check(selected_n, 1);
    check(16'(expQ.size()), 0);
    wrap_up;
  end
endmodule // testbench
bind winchester_drive_control_interface drv_sva chk (.mclk, .nrst,
  .seekDone_n, .outer_track_n, .writeFault_n, .index_n, .selected_n,
  .rd_flux_p, .rd_flux_n, .writeEnable, .readEnable, .reducedWrite,
  .fluxReverse, .track);
`default_nettype wire
